// ===== rtl/stlp_cfg.svh
// Constants of the serial transceiver lane port: offsets, fields, resets, codes, counts.
// Assumes it is included by its bare name before the package and the module.
`ifndef STLP_CFG_SVH
`define STLP_CFG_SVH
// Default number of lanes and bytes per lane word.
`define STLP_LANES        4
`define STLP_BYTES        4
// APB address width and register byte offsets.
`define STLP_ADDR_W       8
`define STLP_OFF_CTRL     8'h00
`define STLP_OFF_STAT     8'h04
`define STLP_OFF_IRQ_STAT 8'h08
`define STLP_OFF_IRQ_MASK 8'h0c
// Control register fields and reset value.
`define STLP_CTRL_W       2
`define STLP_CTRL_SOFT    0
`define STLP_CTRL_FINH    1
`define STLP_CTRL_RST     2'h0
// Status register fields.
`define STLP_STAT_DONE    0
`define STLP_STAT_ALIGN   8
`define STLP_STAT_REQ     16
`define STLP_STAT_LOCK    17
// Interrupt status and mask layout and reset value.
`define STLP_IRQ_W        4
`define STLP_IRQ_REQ      0
`define STLP_IRQ_DISP     1
`define STLP_IRQ_CODE     2
`define STLP_IRQ_DONE     3
`define STLP_IRQ_RST      4'h0
// Control characters recognised on receive.
`define STLP_COMMA_A      8'hbc
`define STLP_COMMA_B      8'h3c
`define STLP_COMMA_C      8'hfc
`define STLP_BOND_CHAR    8'h7c
// Coding-rate ticks a lane waits after its reset is released.
`define STLP_RST_TICKS    4
`endif

// ===== rtl/stlp_pkg.sv
// Types shared by the serial transceiver lane port.
// Assumes the configuration header is compiled alongside.
package stlp_pkg;
   // Per-lane reset sequence states.
   typedef enum logic [1:0] {LANE_RESET, LANE_SETTLE, LANE_READY} stlp_lane_st_t;
   // One received or transmitted byte.
   typedef logic [7:0] stlp_byte_t;
endpackage

// ===== rtl/stlp_lane_port.sv
// Parallel side of a multi-lane serial transceiver: transmit, receive, bonding, resets.
// Assumes the line side shares CLK_I, the clock lock is asynchronous, APB on CLK_I.
//
// The address map and the APB slave port are this design's own decisions.
`timescale 1ns/100ps
`include "stlp_cfg.svh"

// Behaviour
// [R1] Interface clock phase aligned, rate from line
// [R2] Coding clock is exactly half interface clock
// [R3] Coding reset released synchronously to coding clock
// [R4] Clocks unusable while lock qualifier is low
// [R5] Transmit 32 bits per lane, byte control flags
// [R6] Inhibit bit disables that lane's transmitter
// [R7] Deliver receive words with control flags
// [R8] Flag comma characters per received byte
// [R9] Flag running disparity errors per byte
// [R10] Flag code groups missing from decode table
// [R11] Report bonding sequence received per lane
// [R12] Report lane aligned with bonding master lane
// [R13] Request reset on elastic buffer errors
// [R14] Reset lanes while transceiver reset asserted
// [R15] Per-lane reset done after reset sequence
// [R16] Bond lanes only while bonding enable set
// [R17] Reset done low in reset, rises after
module stlp_lane_port
   import stlp_pkg::*;
#(
   parameter int LANE_COUNT = `STLP_LANES,
   parameter int RST_TICKS  = `STLP_RST_TICKS
)
(
   input  logic                      CLK_I,
   input  logic                      RESET_I,
   input  logic                      PSEL_I,
   input  logic                      PENABLE_I,
   input  logic                      PWRITE_I,
   input  logic [`STLP_ADDR_W-1:0]   PADDR_I,
   input  logic [31:0]               PWDATA_I,
   output logic [31:0]               PRDATA_O,
   output logic                      PREADY_O,
   output logic                      PSLVERR_O,
   output logic                      IRQ_O,
   input  logic                      CLK_LOCK_I,
   input  logic                      CODING_SIDE_RESET_I,
   input  logic                      XCVR_RESET_I,
   input  logic                      BOND_EN_I,
   input  logic [32*LANE_COUNT-1:0]  TX_DATA_I,
   input  logic [4*LANE_COUNT-1:0]   TX_CTRL_I,
   input  logic [LANE_COUNT-1:0]     TX_INHIBIT_I,
   output logic [32*LANE_COUNT-1:0]  LINE_TX_DATA_O,
   output logic [4*LANE_COUNT-1:0]   LINE_TX_CTRL_O,
   output logic [LANE_COUNT-1:0]     LINE_TX_EN_O,
   input  logic [32*LANE_COUNT-1:0]  LINE_RX_DATA_I,
   input  logic [4*LANE_COUNT-1:0]   LINE_RX_CTRL_I,
   input  logic [4*LANE_COUNT-1:0]   LINE_RX_DISP_ERR_I,
   input  logic [4*LANE_COUNT-1:0]   LINE_RX_CODE_ERR_I,
   input  logic [LANE_COUNT-1:0]     LINE_RX_EB_ERR_I,
   output logic [32*LANE_COUNT-1:0]  RX_DATA_O,
   output logic [4*LANE_COUNT-1:0]   RX_CTRL_O,
   output logic [4*LANE_COUNT-1:0]   RX_COMMA_O,
   output logic [4*LANE_COUNT-1:0]   RX_DISP_ERR_O,
   output logic [4*LANE_COUNT-1:0]   RX_CODE_ERR_O,
   output logic [LANE_COUNT-1:0]     RX_BOND_SEQ_O,
   output logic [LANE_COUNT-1:0]     RX_ALIGNED_O,
   output logic                      RESET_REQ_O,
   output logic [LANE_COUNT-1:0]     RESET_DONE_O
);

   localparam int NB = `STLP_BYTES * LANE_COUNT;

   // Returns one when a control byte is one of the comma characters.
   function automatic logic is_comma(input stlp_byte_t b, input logic k);
      is_comma = k && (b == `STLP_COMMA_A || b == `STLP_COMMA_B || b == `STLP_COMMA_C);
   endfunction

   // Returns one when a lane word opens with the bonding character.
   function automatic logic is_bond(input stlp_byte_t b, input logic k);
      is_bond = k && (b == `STLP_BOND_CHAR);
   endfunction

   //**********************************************************************
   // Input synchronisers and the coding-rate divider
   //**********************************************************************

   logic [2:0]  lock_sync_r;         // Clock lock through three stages.
   logic        locked_r;            // Filtered clock lock level.
   logic [2:0]  crst_sync_r;         // Coding-side reset through three stages.
   logic        crst_r;              // Filtered coding-side reset level.
   logic        half_r;              // Divider phase toggling every cycle.
   logic        code_en_r;           // One-cycle pulse at the coding rate.
   logic        lane_rst_r;          // Common lane reset.
   logic [`STLP_CTRL_W-1:0] ctrl_r;  // Software control bits.

   // The lock qualifier changes only once the second and third stage agree.
   always_ff @(posedge CLK_I)
   begin
      if (RESET_I)
      begin
         lock_sync_r <= 3'h0;
         locked_r    <= 1'b0;
      end
      else
      begin
         lock_sync_r <= {lock_sync_r[1:0], CLK_LOCK_I};
         if (lock_sync_r[1] == lock_sync_r[2])
         begin
            locked_r <= lock_sync_r[2];
         end
      end
   end

   // The coding-side reset may arrive at any time; its release is re-timed here.
   always_ff @(posedge CLK_I)
   begin
      if (RESET_I)
      begin
         crst_sync_r <= 3'h7;
         crst_r      <= 1'b1;
      end
      else
      begin
         crst_sync_r <= {crst_sync_r[1:0], CODING_SIDE_RESET_I};
         if (crst_sync_r[1] == crst_sync_r[2])
         begin
            crst_r <= crst_sync_r[2];  // R3
         end
      end
   end

   // Half-rate enable stands in for the coding clock.
   always_ff @(posedge CLK_I)
   begin
      if (RESET_I)
      begin
         half_r    <= 1'b0;
         code_en_r <= 1'b0;
      end
      else
      begin
         half_r    <= ~half_r;
         code_en_r <= half_r;  // R2
      end
   end

   // Lanes are held while any reset is active or the clocks are not locked.
   always_ff @(posedge CLK_I)
   begin
      if (RESET_I)
      begin
         lane_rst_r <= 1'b1;
      end
      else
      begin
         lane_rst_r <= XCVR_RESET_I | crst_r | ~locked_r | ctrl_r[`STLP_CTRL_SOFT];  // R4 R14
      end
   end

   //**********************************************************************
   // Per-lane transmit, receive, bonding and reset sequence
   //**********************************************************************

   logic [NB-1:0]         comma_nxt;   // Comma decode of the incoming bytes.
   logic [LANE_COUNT-1:0] bond_nxt;    // Bonding character seen per lane.
   logic [LANE_COUNT-1:0] done_nxt;    // Lane finished its reset sequence.

   genvar gb;
   generate
      for (gb = 0; gb < NB; gb++)
      begin : g_byte
         assign comma_nxt[gb] = is_comma(LINE_RX_DATA_I[8*gb +: 8], LINE_RX_CTRL_I[gb]);
      end
   endgenerate

   genvar gl;
   generate
      for (gl = 0; gl < LANE_COUNT; gl++)
      begin : g_lane
         stlp_lane_st_t st_r;      // Reset sequence state.
         logic [7:0]    tick_r;    // Coding ticks spent settling.

         assign bond_nxt[gl] = is_bond(LINE_RX_DATA_I[32*gl +: 8], LINE_RX_CTRL_I[4*gl]);
         assign done_nxt[gl] = (st_r == LANE_READY);

         // Transmit word with its control flags; an inhibited lane stays silent.
         always_ff @(posedge CLK_I)
         begin
            if (RESET_I || lane_rst_r)
            begin
               LINE_TX_DATA_O[32*gl +: 32] <= 32'h0;
               LINE_TX_CTRL_O[4*gl +: 4]   <= 4'h0;
               LINE_TX_EN_O[gl]            <= 1'b0;
            end
            else if (TX_INHIBIT_I[gl] || ctrl_r[`STLP_CTRL_FINH])
            begin
               LINE_TX_DATA_O[32*gl +: 32] <= 32'h0;  // R6
               LINE_TX_CTRL_O[4*gl +: 4]   <= 4'h0;
               LINE_TX_EN_O[gl]            <= 1'b0;
            end
            else
            begin
               LINE_TX_DATA_O[32*gl +: 32] <= TX_DATA_I[32*gl +: 32];  // R5
               LINE_TX_CTRL_O[4*gl +: 4]   <= TX_CTRL_I[4*gl +: 4];
               LINE_TX_EN_O[gl]            <= 1'b1;
            end
         end

         // Bonding: sequence seen with the master lane marks the lane aligned.
         always_ff @(posedge CLK_I)
         begin
            if (RESET_I || lane_rst_r || !BOND_EN_I)
            begin
               RX_BOND_SEQ_O[gl] <= 1'b0;  // R16
               RX_ALIGNED_O[gl]  <= 1'b0;
            end
            else
            begin
               RX_BOND_SEQ_O[gl] <= bond_nxt[gl];  // R11
               if (bond_nxt[gl] && bond_nxt[0])
               begin
                  RX_ALIGNED_O[gl] <= 1'b1;  // R12
               end
            end
         end

         // Reset sequence: wait a number of coding ticks after release.
         always_ff @(posedge CLK_I)
         begin
            if (RESET_I || lane_rst_r)
            begin
               st_r   <= LANE_RESET;
               tick_r <= 8'h0;
            end
            else
            begin
               case (st_r)
                  LANE_RESET:
                  begin
                     st_r <= LANE_SETTLE;
                  end
                  LANE_SETTLE:
                  begin
                     if (code_en_r)
                     begin
                        tick_r <= tick_r + 8'h1;
                        if (tick_r == 8'(RST_TICKS - 1))
                        begin
                           st_r <= LANE_READY;  // R15
                        end
                     end
                  end
                  LANE_READY:
                  begin
                     st_r <= LANE_READY;
                  end
                  default:
                  begin
                     st_r <= LANE_RESET;
                  end
               endcase
            end
         end
      end
   endgenerate

   // Received words and per-byte flags; all cleared while lanes are in reset.
   always_ff @(posedge CLK_I)
   begin
      if (RESET_I || lane_rst_r)
      begin
         RX_DATA_O     <= '0;
         RX_CTRL_O     <= '0;
         RX_COMMA_O    <= '0;
         RX_DISP_ERR_O <= '0;
         RX_CODE_ERR_O <= '0;
      end
      else
      begin
         RX_DATA_O     <= LINE_RX_DATA_I;      // R7
         RX_CTRL_O     <= LINE_RX_CTRL_I;
         RX_COMMA_O    <= comma_nxt;           // R8
         RX_DISP_ERR_O <= LINE_RX_DISP_ERR_I;  // R9
         RX_CODE_ERR_O <= LINE_RX_CODE_ERR_I;  // R10
      end
   end

   // Reset-done vector follows the lane states and is low in reset.
   always_ff @(posedge CLK_I)
   begin
      if (RESET_I || lane_rst_r)
      begin
         RESET_DONE_O <= '0;  // R17
      end
      else
      begin
         RESET_DONE_O <= done_nxt;
      end
   end

   // Reset request: a buffer error sets it, the transceiver reset clears it.
   always_ff @(posedge CLK_I)
   begin
      if (RESET_I)
      begin
         RESET_REQ_O <= 1'b0;
      end
      else
      begin
         RESET_REQ_O <= (|LINE_RX_EB_ERR_I) | (RESET_REQ_O & ~XCVR_RESET_I);  // R13
      end
   end

   //**********************************************************************
   // APB register slave and interrupt
   //**********************************************************************

   logic [`STLP_IRQ_W-1:0] irq_stat_r;  // Sticky event bits.
   logic [`STLP_IRQ_W-1:0] irq_mask_r;  // Enables of the event bits.
   logic [`STLP_IRQ_W-1:0] irq_ev;      // Events of this cycle.
   logic [31:0]            rd_nxt;      // Read data chosen at setup.
   logic                   rd_ok;       // Address is mapped.
   logic                   wr_acc;      // Write taken this edge.
   logic                   all_done_r;  // All lanes were done last cycle.

   assign wr_acc = PSEL_I & PENABLE_I & PWRITE_I & PREADY_O;

   // Read multiplexer; unmapped addresses read zero with an error.
   always_comb
   begin
      rd_nxt = 32'h0;
      rd_ok  = 1'b1;
      case (PADDR_I)
         `STLP_OFF_CTRL:     rd_nxt[`STLP_CTRL_W-1:0] = ctrl_r;
         `STLP_OFF_STAT:
         begin
            rd_nxt[`STLP_STAT_DONE +: LANE_COUNT]  = RESET_DONE_O;
            rd_nxt[`STLP_STAT_ALIGN +: LANE_COUNT] = RX_ALIGNED_O;
            rd_nxt[`STLP_STAT_REQ]                 = RESET_REQ_O;
            rd_nxt[`STLP_STAT_LOCK]                = locked_r;
         end
         `STLP_OFF_IRQ_STAT: rd_nxt[`STLP_IRQ_W-1:0] = irq_stat_r;
         `STLP_OFF_IRQ_MASK: rd_nxt[`STLP_IRQ_W-1:0] = irq_mask_r;
         default:            rd_ok = 1'b0;
      endcase
   end

   // Answer is ready in the first access cycle; data captured in setup.
   always_ff @(posedge CLK_I)
   begin
      if (RESET_I)
      begin
         PRDATA_O  <= 32'h0;
         PREADY_O  <= 1'b0;
         PSLVERR_O <= 1'b0;
      end
      else
      begin
         PREADY_O <= 1'b1;
         if (PSEL_I && !PENABLE_I)
         begin
            PRDATA_O  <= PWRITE_I ? 32'h0 : rd_nxt;
            PSLVERR_O <= ~rd_ok;
         end
      end
   end

   // Control and mask registers written at the access edge.
   always_ff @(posedge CLK_I)
   begin
      if (RESET_I)
      begin
         ctrl_r     <= `STLP_CTRL_RST;
         irq_mask_r <= `STLP_IRQ_RST;
      end
      else if (wr_acc)
      begin
         if (PADDR_I == `STLP_OFF_CTRL)
         begin
            ctrl_r <= PWDATA_I[`STLP_CTRL_W-1:0];
         end
         if (PADDR_I == `STLP_OFF_IRQ_MASK)
         begin
            irq_mask_r <= PWDATA_I[`STLP_IRQ_W-1:0];
         end
      end
   end

   // Events: buffer error, disparity error, code error, all lanes done.
   always_comb
   begin
      irq_ev                 = '0;
      irq_ev[`STLP_IRQ_REQ]  = |LINE_RX_EB_ERR_I;
      irq_ev[`STLP_IRQ_DISP] = |RX_DISP_ERR_O;
      irq_ev[`STLP_IRQ_CODE] = |RX_CODE_ERR_O;
      irq_ev[`STLP_IRQ_DONE] = (&RESET_DONE_O) & ~all_done_r;
   end

   // Sticky status cleared by writing one; a new event wins over the clear.
   always_ff @(posedge CLK_I)
   begin
      if (RESET_I)
      begin
         irq_stat_r <= `STLP_IRQ_RST;
         all_done_r <= 1'b0;
         IRQ_O      <= 1'b0;
      end
      else
      begin
         all_done_r <= &RESET_DONE_O;
         if (wr_acc && PADDR_I == `STLP_OFF_IRQ_STAT)
         begin
            irq_stat_r <= (irq_stat_r & ~PWDATA_I[`STLP_IRQ_W-1:0]) | irq_ev;
         end
         else
         begin
            irq_stat_r <= irq_stat_r | irq_ev;
         end
         IRQ_O <= |(irq_stat_r & irq_mask_r);
      end
   end

   //**********************************************************************
   // Assertions
   //**********************************************************************

   sequence s_quiet;
      lane_rst_r ##1 (!lane_rst_r) [*8];
   endsequence

   property p_inhibit;
      @(posedge CLK_I) disable iff (RESET_I) TX_INHIBIT_I[0] |=> !LINE_TX_EN_O[0];
   endproperty
   a_inhibit: assert property (p_inhibit) else $error("inhibited lane enabled");  // R6

   property p_tx;
      @(posedge CLK_I) disable iff (RESET_I)
         (!lane_rst_r && !TX_INHIBIT_I[0] && !ctrl_r[`STLP_CTRL_FINH])
         |=> LINE_TX_DATA_O[31:0] == $past(TX_DATA_I[31:0]);
   endproperty
   a_tx: assert property (p_tx) else $error("transmit word lost");  // R5

   property p_rx;
      @(posedge CLK_I) disable iff (RESET_I)
         !lane_rst_r |=> RX_DATA_O == $past(LINE_RX_DATA_I) && RX_CTRL_O == $past(LINE_RX_CTRL_I);
   endproperty
   a_rx: assert property (p_rx) else $error("receive word lost");  // R7

   property p_comma;
      @(posedge CLK_I) disable iff (RESET_I)
         (!lane_rst_r && LINE_RX_CTRL_I[0] && LINE_RX_DATA_I[7:0] == `STLP_COMMA_A)
         |=> RX_COMMA_O[0];
   endproperty
   a_comma: assert property (p_comma) else $error("comma not flagged");  // R8

   property p_err;
      @(posedge CLK_I) disable iff (RESET_I)
         !lane_rst_r |=> RX_DISP_ERR_O == $past(LINE_RX_DISP_ERR_I)
                      && RX_CODE_ERR_O == $past(LINE_RX_CODE_ERR_I);
   endproperty
   a_err: assert property (p_err) else $error("error flag mismatch");  // R9 R10

   property p_bond;
      @(posedge CLK_I) disable iff (RESET_I)
         (!lane_rst_r && BOND_EN_I && bond_nxt[0]) |=> RX_BOND_SEQ_O[0] && RX_ALIGNED_O[0];
   endproperty
   a_bond: assert property (p_bond) else $error("bonding not reported");  // R11 R12

   property p_nobond;
      @(posedge CLK_I) disable iff (RESET_I) !BOND_EN_I |=> RX_ALIGNED_O == '0;
   endproperty
   a_nobond: assert property (p_nobond) else $error("aligned without bonding");  // R16

   property p_req;
      @(posedge CLK_I) disable iff (RESET_I)
         (|LINE_RX_EB_ERR_I) |=> RESET_REQ_O ##1 (RESET_REQ_O || $past(XCVR_RESET_I));
   endproperty
   a_req: assert property (p_req) else $error("reset request missing");  // R13

   property p_rst_done;
      @(posedge CLK_I) disable iff (RESET_I) XCVR_RESET_I |=> ##1 RESET_DONE_O == '0;
   endproperty
   a_rst_done: assert property (p_rst_done) else $error("done during reset");  // R14 R17

   property p_done;
      @(posedge CLK_I) disable iff (RESET_I)
         s_quiet |-> ##[0:4] (RESET_DONE_O[0] || lane_rst_r);
   endproperty
   a_done: assert property (p_done) else $error("reset done late");  // R15

endmodule

// ===== testbench/stlp_phy_model.sv
// Model of the physical-layer logic that feeds the lane port: clocks, resets, bonding, transmit.
// Assumes it shares the lane port's clock and that the package is compiled first.
`timescale 1ns/100ps
module stlp_phy_model
   import stlp_pkg::*;
#(
   parameter int LANE_COUNT = 4
)
(
   input  wire logic                clk_i,
   output logic                     lock_o,
   output logic                     coding_rst_o,
   output logic                     xcvr_rst_o,
   output logic                     bond_en_o,
   output logic [32*LANE_COUNT-1:0] tx_data_o,
   output logic [4*LANE_COUNT-1:0]  tx_ctrl_o,
   output logic [LANE_COUNT-1:0]    tx_inh_o
);
   // ******************************
   // Half-rate coding tick
   // ******************************
   logic tick_r = 1'b0; // Coding clock at half the interface rate, in phase.

   // Toggles on every edge so that it is high on every second edge.
   always @(posedge clk_i)
      tick_r <= ~tick_r;

   // Clocks start invalid and every reset starts asserted.
   initial
   begin
      lock_o = 1'b0;
      coding_rst_o = 1'b1;
      xcvr_rst_o = 1'b1;
      bond_en_o = 1'b0;
      tx_data_o = '0;
      tx_ctrl_o = '0;
      tx_inh_o = '0;
   end

   // ******************************
   // Requests from the bench
   // ******************************
   // Marks the clocks valid, then frees the coding reset on a coding tick.
   task bring_up;
      @(posedge clk_i);
      lock_o <= 1'b1;
      xcvr_rst_o <= 1'b0;
      repeat (6) @(posedge clk_i);
      while (tick_r !== 1'b1) @(posedge clk_i);
      coding_rst_o <= 1'b0;
   endtask

   // Sets the transceiver reset and the bonding enable.
   task drive(input logic xr, input logic bd);
      @(posedge clk_i);
      xcvr_rst_o <= xr;
      bond_en_o <= bd;
   endtask

   // Presents one transmit word with its byte flags and lane inhibits.
   task send_tx(input logic [32*LANE_COUNT-1:0] d, input logic [4*LANE_COUNT-1:0] c,
                input logic [LANE_COUNT-1:0] i);
      @(posedge clk_i);
      tx_data_o <= d;
      tx_ctrl_o <= c;
      tx_inh_o <= i;
   endtask
endmodule

// ===== testbench/serial_transceiver_lane_port_tb_top.sv
// Self-checking bench of the lane port: bring-up, streams, bonding, reset request, registers.
// Assumes the configuration header, package, design and physical-layer model compile first.
`timescale 1ns/100ps
`include "stlp_cfg.svh"
module serial_transceiver_lane_port_tb_top
   import stlp_pkg::*;
;
   localparam int L = 4; // Lane count under test.
   logic clk, rst, psel, pen, pwr, er, irq, pready, pslverr, lock, crst, xrst, bond, rreq;
   logic [7:0]     paddr;
   logic [31:0]    pwdata, prdata, rd;
   logic [127:0]   txd, ltxd, lrxd, rxd;
   logic [15:0]    txc, ltxc, lrxc, lrxdp, lrxcd, rxc, rxcm, rxdp, rxcd;
   logic [L-1:0]   txi, ltxe, lrxeb, rxbond, rxal, rdone;
   int             num_errors, compares;

   stlp_phy_model #(.LANE_COUNT(L)) pm (.clk_i(clk), .lock_o(lock), .coding_rst_o(crst),
      .xcvr_rst_o(xrst), .bond_en_o(bond), .tx_data_o(txd), .tx_ctrl_o(txc), .tx_inh_o(txi));

   stlp_lane_port #(.LANE_COUNT(L), .RST_TICKS(4)) uut (.CLK_I(clk), .RESET_I(rst),
      .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata),
      .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr), .IRQ_O(irq),
      .CLK_LOCK_I(lock), .CODING_SIDE_RESET_I(crst), .XCVR_RESET_I(xrst), .BOND_EN_I(bond),
      .TX_DATA_I(txd), .TX_CTRL_I(txc), .TX_INHIBIT_I(txi), .LINE_TX_DATA_O(ltxd),
      .LINE_TX_CTRL_O(ltxc), .LINE_TX_EN_O(ltxe), .LINE_RX_DATA_I(lrxd),
      .LINE_RX_CTRL_I(lrxc), .LINE_RX_DISP_ERR_I(lrxdp), .LINE_RX_CODE_ERR_I(lrxcd),
      .LINE_RX_EB_ERR_I(lrxeb), .RX_DATA_O(rxd), .RX_CTRL_O(rxc), .RX_COMMA_O(rxcm),
      .RX_DISP_ERR_O(rxdp), .RX_CODE_ERR_O(rxcd), .RX_BOND_SEQ_O(rxbond),
      .RX_ALIGNED_O(rxal), .RESET_REQ_O(rreq), .RESET_DONE_O(rdone));

   // ******************************
   // Shared helpers
   // ******************************
   // Counts a comparison and reports a mismatch at once.
   task chk(input string nm, input logic [127:0] seen, input logic [127:0] exp);
      compares++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // Lets one edge land, then looks between edges.
   task settle;
      @(posedge clk);
      @(negedge clk);
   endtask

   // One APB transfer; waits for the slave's ready, bounded by the watchdog.
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pen <= 1'b0;
      pwr <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask

   // Presents one word on the line receive side.
   task rx(input logic [127:0] d, input logic [15:0] c, dp, cd, input logic [L-1:0] eb);
      @(posedge clk);
      lrxd <= d;
      lrxc <= c;
      lrxdp <= dp;
      lrxcd <= cd;
      lrxeb <= eb;
   endtask

   // Waits a bounded time for every lane to finish its reset.
   task wait_done;
      for (int i = 0; i < 60 && rdone !== 4'hf; i++) @(negedge clk);
      chk("reset done", rdone, 4'hf);
   endtask

   // ******************************
   // Scenarios
   // ******************************
   // Lanes come out of reset once clocks are valid; status shows it.
   task t_bringup;
      pm.bring_up;
      wait_done;
      apb(1'b0, `STLP_OFF_STAT, 32'h0);
      chk("status", rd, 32'h0002000f);
   endtask

   // Each lane inhibited in turn while a word with control bytes is sent.
   task t_tx;
      logic [127:0] d;
      d = 128'h0f0e0d0c_0b0a0908_07060504_03020100;
      for (int k = 0; k < L; k++)
      begin
         pm.send_tx(d, 16'ha5c3, 4'h1 << k);
         settle;
         chk("tx data", ltxd, d & ~(128'hffffffff << (32 * k)));
         chk("tx ctrl", ltxc, 16'ha5c3 & ~(16'hf << (4 * k)));
         chk("tx enable", ltxe, 4'hf ^ (4'h1 << k));
      end
   endtask

   // Receive word with commas, a bonding character and decode errors.
   task t_rx;
      rx(128'h000000fc_0000007c_0000003c_112233bc, 16'h1111, 16'h0020, 16'h8000, 4'h0);
      settle;
      chk("rx data", rxd, 128'h000000fc_0000007c_0000003c_112233bc);
      chk("rx ctrl", rxc, 16'h1111);
      chk("rx comma", rxcm, 16'h1011);
      chk("rx disparity", rxdp, 16'h0020);
      chk("rx code", rxcd, 16'h8000);
      chk("bond off", rxbond, 4'h0);
      apb(1'b0, `STLP_OFF_IRQ_STAT, 32'h0);
      chk("irq status", rd, 32'h0000000e);
   endtask

   // Bonding sequence on all lanes, then bonding switched off.
   task t_bond;
      pm.drive(1'b0, 1'b1);
      rx({4{32'h0000007c}}, 16'h1111, 16'h0, 16'h0, 4'h0);
      settle;
      chk("bond seq", rxbond, 4'hf);
      chk("aligned", rxal, 4'hf);
      pm.drive(1'b0, 1'b0);
      settle;
      chk("bond seq off", rxbond, 4'h0);
      chk("aligned off", rxal, 4'h0);
   endtask

   // Elastic buffer error raises a request and an interrupt; reset clears it.
   task t_req;
      apb(1'b1, `STLP_OFF_IRQ_MASK, 32'h1);
      apb(1'b1, `STLP_OFF_IRQ_STAT, 32'hf);
      rx(128'h0, 16'h0, 16'h0, 16'h0, 4'h4);
      rx(128'h0, 16'h0, 16'h0, 16'h0, 4'h0);
      @(negedge clk);
      chk("reset request", rreq, 1'b1);
      settle;
      chk("irq raised", irq, 1'b1);
      apb(1'b1, `STLP_OFF_IRQ_STAT, 32'h1);
      settle;
      settle;
      chk("irq cleared", irq, 1'b0);
      pm.drive(1'b1, 1'b0);
      settle;
      chk("request cleared", rreq, 1'b0);
      settle;
      chk("done in reset", rdone, 4'h0);
      chk("tx off in reset", ltxe, 4'h0);
      pm.drive(1'b0, 1'b0);
      wait_done;
   endtask

   // Unmapped address is refused; forced inhibit silences every lane.
   task t_regs;
      apb(1'b0, 8'h10, 32'h0);
      chk("unmapped error", er, 1'b1);
      chk("unmapped data", rd, 32'h0);
      apb(1'b0, `STLP_OFF_CTRL, 32'h0);
      chk("ctrl reset", rd, 32'h0);
      chk("mapped error", er, 1'b0);
      apb(1'b1, `STLP_OFF_CTRL, 32'h2);
      pm.send_tx(128'h1, 16'h1, 4'h0);
      settle;
      chk("forced inhibit", ltxe, 4'h0);
      apb(1'b1, `STLP_OFF_CTRL, 32'h1);
      settle;
      settle;
      chk("soft reset done", rdone, 4'h0);
      apb(1'b1, `STLP_OFF_CTRL, 32'h0);
      wait_done;
   endtask

   // ******************************
   // Clock, sequence and verdict
   // ******************************
   // Prints the counts and the verdict, then stops.
   task close_out;
      $display("compares %0d num_errors %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // Free-running 100 MHz clock.
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // Cuts a hang short well beyond the expected run.
   initial
   begin
      repeat (20000) @(posedge clk);
      num_errors++;
      close_out;
   end

   // Reset, then every scenario in turn.
   initial
   begin
      {psel, pen, pwr, paddr, pwdata} = '0;
      {lrxd, lrxc, lrxdp, lrxcd, lrxeb} = '0;
      num_errors = 0;
      compares = 0;
      rst = 1'b1;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      repeat (2) @(posedge clk);
      t_bringup;
      t_tx;
      t_rx;
      t_bond;
      t_req;
      t_regs;
      close_out;
   end
endmodule
